//--- wdt_refresh_timeout.sv
// Watchdog down-counter with refresh, debug hold-off and time-out response
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
// Notes on behaviour
// R1: On first enable, load counter from reload register before counting.
// R2: Counter decrements once per tick toward zero unless refreshed.
// R3: Refresh instruction reloads counter from reload value; counting then resumes.
// R4: During debug the watchdog is refreshed every cycle; no time-out.
// R5: Time-out is declared when the counter reaches zero.
// R6: Option bit picks system reset or interrupt as time-out response.
// R7: Interrupt response pulses interrupt request and sets watchdog flag.
// R8: After interrupt time-out counter wraps to all ones and keeps counting.
// R9: No automatic reload after interrupt time-out; only refresh reloads.
// R10: Reading the reset cause register clears the watchdog flag.
// R11: Software reads the cause register before clearing the pending interrupt.
// R12: Time-out in STOP with interrupt response starts recovery and interrupts.
// R13: Time-out in STOP sets both watchdog and stop flags; here only with interrupt response, a reset-response time-out sets neither.
// R14: Reset response gives one-cycle reset request and no interrupt.
module wdt_refresh_timeout
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [`WDT_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // CPU and system status
   input wire logic refresh_i,
   input wire logic debug_i,
   input wire logic stop_mode_i,
   input wire logic timeout_response_select_i,
   // Events to neighbours
   output logic irq_o,
   output logic sys_reset_req_o,
   output logic stop_recover_o
);
   wdt_pkg::wdt_state_t state_r;
   logic [`WDT_CNT_W-1:0] cnt_r;
   logic [`WDT_CNT_W-1:0] reload_r;
   logic en_r;
   logic watchdog_timeout_flag_r;
   logic stop_flag_r;
   logic tick;
   logic timeout;
   logic refresh;
   logic cause_rd;
   logic ctrl_sel;
   logic reload_sel;
   logic count_sel;
   logic status_sel;
   logic ctrl_wr;
   logic reload_wr;
   logic running;
   logic count_tick;
   logic cnt_load;
   logic cnt_wrap;
   logic cnt_dec;
   logic resp_irq;
   logic resp_rst;
   logic resp_wake;
   logic flag_set;
   logic stop_set;
   logic [31:0] rd_word;

   wdt_tick_div u_div
   (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .tick_o(tick)
   );

   // Debug acts as a refresh every cycle, so zero is never reached
   assign refresh = refresh_i | debug_i; // R4
   // Counting happens only in the run state
   assign running = (state_r == wdt_pkg::WDT_RUN);
   // A refresh outranks the tick that meets it
   assign count_tick = running && tick && !refresh;
   // Zero is reached on the tick that finds count at one
   assign timeout = count_tick && (cnt_r == `WDT_CNT_ONE); // R5

   // Register index decode, one select per register
   always_comb
   begin
      ctrl_sel = 1'b0;
      reload_sel = 1'b0;
      count_sel = 1'b0;
      status_sel = 1'b0;
      case (addr_i)
         `WDT_OFF_CTRL:
         begin
            ctrl_sel = 1'b1;
         end
         `WDT_OFF_RELOAD:
         begin
            reload_sel = 1'b1;
         end
         `WDT_OFF_COUNT:
         begin
            count_sel = 1'b1;
         end
         `WDT_OFF_STATUS:
         begin
            status_sel = 1'b1;
         end
         default:
         begin
            ctrl_sel = 1'b0;
         end
      endcase
   end

   // Unmapped writes match no select and are dropped
   assign ctrl_wr = wr_i && ctrl_sel;
   assign reload_wr = wr_i && reload_sel;
   // Reading the status word is what clears the cause flags
   assign cause_rd = rd_i && status_sel;

   // Software enable
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         en_r <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         en_r <= wdata_i[`WDT_BIT_EN];
      end
   end

   // Reload value; a new value only counts from the next load or refresh
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         reload_r <= `WDT_RELOAD_RST;
      end
      else if (reload_wr)
      begin
         reload_r <= wdata_i[`WDT_CNT_W-1:0];
      end
   end

   // Enable sequencing; disabling and enabling again reloads
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_r <= wdt_pkg::WDT_OFF;
      end
      else
      begin
         case (state_r)
            wdt_pkg::WDT_OFF:
            begin
               if (en_r)
               begin
                  state_r <= wdt_pkg::WDT_LOAD; // R1
               end
            end
            wdt_pkg::WDT_LOAD:
            begin
               state_r <= wdt_pkg::WDT_RUN;
            end
            wdt_pkg::WDT_RUN:
            begin
               if (!en_r)
               begin
                  state_r <= wdt_pkg::WDT_OFF;
               end
            end
            default:
            begin
               state_r <= wdt_pkg::WDT_OFF;
            end
         endcase
      end
   end

   // Counter actions, one at most per cycle
   // A zero reload wraps on its first tick rather than timing out
   always_comb
   begin
      cnt_load = 1'b0;
      cnt_wrap = 1'b0;
      cnt_dec = 1'b0;
      if (state_r == wdt_pkg::WDT_LOAD)
      begin
         cnt_load = 1'b1; // R1
      end
      else if (running && refresh)
      begin
         cnt_load = 1'b1; // R3 R4
      end
      else if (count_tick && (cnt_r == `WDT_CNT_ZERO))
      begin
         cnt_wrap = 1'b1; // R8 R9
      end
      else if (count_tick)
      begin
         cnt_dec = 1'b1; // R2
      end
   end

   // Down-counter; the wrap holds for both responses, no reload from hardware
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_r <= `WDT_CNT_MAX;
      end
      else if (cnt_load)
      begin
         cnt_r <= reload_r; // R1 R3
      end
      else if (cnt_wrap)
      begin
         cnt_r <= `WDT_CNT_MAX; // R8 R9
      end
      else if (cnt_dec)
      begin
         cnt_r <= cnt_r - `WDT_CNT_ONE; // R2
      end
   end

   // Response selection; the option bit is read live at each time-out, not latched
   always_comb
   begin
      resp_irq = 1'b0;
      resp_rst = 1'b0;
      resp_wake = 1'b0;
      if (timeout && timeout_response_select_i)
      begin
         resp_irq = 1'b1; // R6 R7
         resp_wake = stop_mode_i; // R12
      end
      else if (timeout)
      begin
         resp_rst = 1'b1; // R6 R14
      end
   end

   // Flags record interrupt-mode time-outs only
   assign flag_set = resp_irq; // R7
   assign stop_set = resp_wake; // R13

   // Time-out responses, one-cycle pulses
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         irq_o <= 1'b0;
         sys_reset_req_o <= 1'b0;
         stop_recover_o <= 1'b0;
      end
      else
      begin
         irq_o <= resp_irq; // R7 R12
         sys_reset_req_o <= resp_rst; // R14
         stop_recover_o <= resp_wake; // R12
      end
   end

   // Watchdog flag; a new time-out wins over the clearing read
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         watchdog_timeout_flag_r <= 1'b0;
      end
      else if (flag_set)
      begin
         watchdog_timeout_flag_r <= 1'b1; // R7 R13
      end
      else if (cause_rd)
      begin
         watchdog_timeout_flag_r <= 1'b0; // R10
      end
   end

   // Stop flag, set only by a time-out taken in STOP
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         stop_flag_r <= 1'b0;
      end
      else if (stop_set)
      begin
         stop_flag_r <= 1'b1; // R13
      end
      else if (cause_rd)
      begin
         stop_flag_r <= 1'b0; // R10
      end
   end

   // Read word assembly; unmapped indices read as zero
   always_comb
   begin
      rd_word = '0;
      if (ctrl_sel)
      begin
         rd_word[`WDT_BIT_EN] = en_r;
      end
      else if (reload_sel)
      begin
         rd_word[`WDT_CNT_W-1:0] = reload_r;
      end
      else if (count_sel)
      begin
         rd_word[`WDT_CNT_W-1:0] = cnt_r;
      end
      else if (status_sel)
      begin
         rd_word[`WDT_BIT_WDFLAG] = watchdog_timeout_flag_r;
         rd_word[`WDT_BIT_STOPFLAG] = stop_flag_r;
      end
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_o <= '0;
      end
      else if (rd_i)
      begin
         rdata_o <= rd_word;
      end
      else
      begin
         rdata_o <= '0;
      end
   end
endmodule
`default_nettype wire

//--- wdt_map.svh
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_CNT_W 24
`define WDT_CNT_MAX 24'hffffff
`define WDT_CNT_ZERO 24'h000000
`define WDT_CNT_ONE 24'h000001
`define WDT_ADDR_W 4
`define WDT_OFF_CTRL 4'h0
`define WDT_OFF_RELOAD 4'h1
`define WDT_OFF_COUNT 4'h2
`define WDT_OFF_STATUS 4'h3
`define WDT_BIT_EN 0
`define WDT_BIT_WDFLAG 0
`define WDT_BIT_STOPFLAG 1
`define WDT_RELOAD_RST 24'h00ffff
`define WDT_TICK_DIV 8'h09
`define WDT_DIV_W 8
`endif

//--- wdt_pkg.sv
// Types shared by the watchdog files
`default_nettype none
package wdt_pkg;
   typedef enum logic [1:0]
   {
      WDT_OFF = 2'b00,
      WDT_LOAD = 2'b01,
      WDT_RUN = 2'b11
   } wdt_state_t;
endpackage
`default_nettype wire

//--- wdt_tick_div.sv
// Divider making the one-cycle count tick enable
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module wdt_tick_div
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Tick
   output logic tick_o
);
   logic [`WDT_DIV_W-1:0] div_r;

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         div_r <= '0;
         tick_o <= 1'b0;
      end
      else if (div_r == `WDT_TICK_DIV)
      begin
         div_r <= '0;
         tick_o <= 1'b1;
      end
      else
      begin
         div_r <= div_r + 8'h01;
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- wdt_refresh_timeout_assertions.sv
// Port checks for the watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module wdt_sva
(
   // Watched ports
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [`WDT_ADDR_W-1:0] addr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic debug_i,
   input wire logic stop_mode_i,
   input wire logic timeout_response_select_i,
   input wire logic irq_o,
   input wire logic sys_reset_req_o,
   input wire logic stop_recover_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_rd_stat;
      rd_i && addr_i == `WDT_OFF_STATUS;
   endsequence
   chk_irq_gap: assert property (irq_o |=> !irq_o [*8]) else $error("irq gap");
   chk_rst_gap: assert property (sys_reset_req_o |=> !sys_reset_req_o [*8]) else $error("rst gap");
   chk_one_response: assert property (!(irq_o && sys_reset_req_o)) else $error("both");
   chk_irq_mode: assert property (irq_o |-> $past(timeout_response_select_i)) else $error("irq");
   chk_rst_mode: assert property (sys_reset_req_o |-> !$past(timeout_response_select_i)) else $error("rst");
   chk_stop_wake: assert property (irq_o |-> stop_recover_o == $past(stop_mode_i)) else $error("wake");
   chk_wake_irq: assert property (stop_recover_o |-> irq_o) else $error("wake alone");
   chk_debug_quiet: assert property ($past(debug_i, 2) && $past(debug_i) |-> !irq_o && !sys_reset_req_o)
      else $error("debug");
   chk_flag_clear: assert property (s_rd_stat ##1 !irq_o ##1 (rd_i && addr_i == `WDT_OFF_STATUS && !irq_o)
      |=> !rdata_o[0]) else $error("flag");
endmodule
`default_nettype wire

//--- wdt_sys_model.sv
// Far side: counts interrupt, reset and wake requests
`timescale 1ns/1ps
`default_nettype none
module wdt_sys_model
(
   // Clock, reset and requests
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic irq_i,
   input wire logic rst_i,
   input wire logic rec_i,
   // Counts
   output int irqs_o,
   output int rsts_o,
   output int recs_o
);
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         irqs_o <= 0;
         rsts_o <= 0;
         recs_o <= 0;
      end
      else
      begin
         irqs_o <= irqs_o + int'(irq_i);
         rsts_o <= rsts_o + int'(rst_i);
         recs_o <= recs_o + int'(rec_i);
      end
endmodule
`default_nettype wire

//--- tb_wdt_refresh_timeout.sv
// Testbench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_wdt_refresh_timeout;
   logic mclk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, refresh_i = 0, debug_i = 0, stop_mode_i = 0;
   logic timeout_response_select_i = 1;
   logic [3:0] addr_i = '0;
   logic [31:0] wdata_i = '0, rdata_o, rv;
   logic irq_o, sys_reset_req_o, stop_recover_o;
   int ni, nr, nw, t, n_mismatch = 0, samples_checked = 0;
   wdt_refresh_timeout DUT (.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .refresh_i, .debug_i, .stop_mode_i, .timeout_response_select_i, .irq_o,
      .sys_reset_req_o, .stop_recover_o);
   wdt_sys_model FAR (.mclk_i, .rstn_i, .irq_i(irq_o), .rst_i(sys_reset_req_o),
      .rec_i(stop_recover_o), .irqs_o(ni), .rsts_o(nr), .recs_o(nw));
   initial forever #50 mclk_i = ~mclk_i;
   task automatic cmp(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %h not %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1;
      @(posedge mclk_i);
      wr_i <= 0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1;
      @(posedge mclk_i);
      rd_i <= 0;
      @(negedge mclk_i);
      rv = rdata_o;
   endtask
   task automatic kick;
      @(posedge mclk_i);
      refresh_i <= 1;
      @(posedge mclk_i);
      refresh_i <= 0;
   endtask
   // Bounded wait for the next irq or reset request
   task automatic wait_ev;
      int s;
      s = ni + nr;
      for (t = 0; ni + nr == s && t < 60; t++)
         @(posedge mclk_i);
   endtask
   task automatic close_out;
      $display("checked %0d, wrong %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge mclk_i);
      rstn_i <= 1;
      wr(4'h1, 32'h3);
      wr(4'h0, 32'h1);
      wait_ev;
      cmp(32'(t > 18 && t < 40), 1);
      rd(4'h3);
      cmp(rv, 1);
      rd(4'h3);
      cmp(rv, 0);
      repeat (12) @(posedge mclk_i);
      rd(4'h2);
      cmp(32'(rv[23:16]), 32'hff);
      $display("irq mode done");
      repeat (8)
      begin
         repeat (12) @(posedge mclk_i);
         kick;
      end
      cmp(ni, 1);
      wait_ev;
      cmp(32'(t > 18 && t < 40), 1);
      kick;
      debug_i <= 1;
      repeat (100) @(posedge mclk_i);
      rd(4'h2);
      cmp(rv, 32'h3);
      cmp(ni, 2);
      @(posedge mclk_i);
      debug_i <= 0;
      stop_mode_i <= 1;
      wait_ev;
      cmp(ni, 32'h3);
      cmp(nw, 32'h1);
      rd(4'h3);
      cmp(rv, 3);
      @(posedge mclk_i);
      stop_mode_i <= 0;
      timeout_response_select_i <= 0;
      kick;
      wait_ev;
      cmp(ni, 32'h3);
      cmp(nr, 32'h1);
      rd(4'h3);
      cmp(rv, 0);
      rd(4'h1);
      cmp(rv, 32'h3);
      rd(4'h0);
      cmp(rv, 32'h1);
      $display("refresh, debug, stop, reset done");
      close_out;
   end
   initial
   begin
      repeat (2000) @(posedge mclk_i);
      n_mismatch++;
      close_out;
   end
endmodule
bind wdt_refresh_timeout wdt_sva CHK (.mclk_i, .rstn_i, .addr_i, .rd_i, .rdata_o, .debug_i,
   .stop_mode_i, .timeout_response_select_i, .irq_o, .sys_reset_req_o, .stop_recover_o);
`default_nettype wire
